// ### shared/ptc_pkg.sv
package ptc_pkg;
    // ==========================================================
    // Two-wire device selects and memory layout
    // ==========================================================
    localparam logic [6:0] DEV_ID = 7'h50;
    localparam logic [6:0] DEV_DIAG = 7'h51;
    localparam logic [7:0] OFS_CTRL = 8'h6e;
    localparam logic [7:0] OFS_TEMP = 8'h60;
    localparam logic [7:0] OFS_VCC = 8'h62;
    localparam logic [7:0] OFS_BIAS = 8'h64;
    localparam logic [7:0] OFS_TXPWR = 8'h66;
    localparam logic [7:0] OFS_RXPWR = 8'h68;
    localparam int BIT_OFF_STATE = 7;
    localparam int BIT_SOFT_OFF = 6;
    localparam int BIT_FAULT = 2;
    localparam int BIT_LOS = 1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic SOFT_OFF_RST = 1'b0;
    localparam logic TX_OFF_RST = 1'b1;
    localparam logic LOS_RST = 1'b1;
    localparam logic LINE_RST = 1'b1;
    localparam logic EVT_RST = 1'b0;
    // ==========================================================
    // Serial slave states
    // ==========================================================
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_AACK, BUS_PTR, BUS_PACK, BUS_WDATA, BUS_RDATA, BUS_RACK
    } ptc_bus_st_t;
endpackage

// ### rtl/ptc_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser
// ==========================================================
module ptc_sync #(
    parameter logic RST = 1'b0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= RST;
            q <= RST;
        end else if (ce) begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule // ptc_sync

// ### rtl/ptc_mgmt.sv
`timescale 1ns/1ps
// Contract
// - 256-byte identification memory readable at bus address 0xA0, bytes 0-255.
// - Separate 256-byte diagnostic memory at 0xA2 with live values and status.
// - Transmit-off input high shuts transmitter; low lets it run.
// - Undriven transmit-off counts as asserted; host drives low to transmit.
// - Byte 110 bit 6 is soft transmit-off; bit 7 reports transmit-off state.
// - Shutdown is OR of soft bit and hardware input.
// - Laser fault disables laser and latches fault output high.
// - Fault clears only by toggling transmit-off or power cycle.
// - Latched fault readable at byte 110 bit 2.
// - Cycling transmit-off after a fault reinitialises transmitter control.
// - Transmit-off and signal-lost states are mirrored into diagnostic memory.
// - Diagnostic memory shows live voltage, temperature, rx power, bias, tx power.
// - Signal-lost output high on loss of light; also byte 110 bit 1.
module ptc_mgmt
    import ptc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic tx_off_in,
    input wire logic laser_fault_in,
    input wire logic rx_lost_in,
    input wire logic [15:0] mon_temp,
    input wire logic [15:0] mon_vcc,
    input wire logic [15:0] mon_bias,
    input wire logic [15:0] mon_txpwr,
    input wire logic [15:0] mon_rxpwr,
    output logic tx_shutdown,
    output logic tx_fault,
    output logic receive_signal_lost
);
    import ptc_pkg::*;

    typedef struct packed {
        ptc_bus_st_t st;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic sel;
        logic rw;
        logic ack;
        logic sda_oe;
        logic sda_out;
        logic scl_q;
        logic sda_q;
        logic off_q;
        logic soft_off;
        logic fault;
        logic tx_shutdown;
        logic tx_fault;
        logic los_out;
        logic [255:0][7:0] id_mem;
        logic [255:0][7:0] dg_mem;
    } ptc_state_t;

    ptc_state_t r_ff;
    ptc_state_t nxt_r;
    logic scl_s, sda_s, off_s, flt_s, los_s;
    logic scl_rise, scl_fall, bus_start, bus_stop, off_fall;
    logic [7:0] rd_val;
    logic [7:0] ctrl_view;
    logic [7:0] mon_view;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Transmit-off resets high so a floating pin keeps the laser dark.
    ptc_sync #(.RST(LINE_RST)) u_scl (.clock(clock), .arst_n(arst_n), .ce(ce), .d(scl_in),
        .q(scl_s));
    ptc_sync #(.RST(LINE_RST)) u_sda (.clock(clock), .arst_n(arst_n), .ce(ce), .d(sda_in),
        .q(sda_s));
    ptc_sync #(.RST(TX_OFF_RST)) u_off (.clock(clock), .arst_n(arst_n), .ce(ce), .d(tx_off_in),
        .q(off_s));
    ptc_sync #(.RST(EVT_RST)) u_flt (.clock(clock), .arst_n(arst_n), .ce(ce), .d(laser_fault_in),
        .q(flt_s));
    ptc_sync #(.RST(LOS_RST)) u_los (.clock(clock), .arst_n(arst_n), .ce(ce), .d(rx_lost_in),
        .q(los_s));

    assign scl_rise = scl_s & ~r_ff.scl_q;
    assign scl_fall = ~scl_s & r_ff.scl_q;
    assign bus_start = scl_s & r_ff.scl_q & r_ff.sda_q & ~sda_s;
    assign bus_stop = scl_s & r_ff.scl_q & ~r_ff.sda_q & sda_s;
    assign off_fall = r_ff.off_q & ~off_s;

    // ==========================================================
    // Memory read view
    // ==========================================================
    function automatic logic [7:0] byte_at(input logic sel, input logic [7:0] a);
        logic [7:0] v;
        v = sel ? r_ff.dg_mem[a] : r_ff.id_mem[a];
        if (sel) begin
            if (a == OFS_TEMP) v = mon_temp[15:8];
            else if (a == OFS_TEMP + 8'h01) v = mon_temp[7:0];
            else if (a == OFS_VCC) v = mon_vcc[15:8];
            else if (a == OFS_VCC + 8'h01) v = mon_vcc[7:0];
            else if (a == OFS_BIAS) v = mon_bias[15:8];
            else if (a == OFS_BIAS + 8'h01) v = mon_bias[7:0];
            else if (a == OFS_TXPWR) v = mon_txpwr[15:8];
            else if (a == OFS_TXPWR + 8'h01) v = mon_txpwr[7:0];
            else if (a == OFS_RXPWR) v = mon_rxpwr[15:8];
            else if (a == OFS_RXPWR + 8'h01) v = mon_rxpwr[7:0];
            else if (a == OFS_CTRL) begin
                v = 8'h00;
                v[BIT_OFF_STATE] = off_s;
                v[BIT_SOFT_OFF] = r_ff.soft_off;
                v[BIT_FAULT] = r_ff.fault;
                v[BIT_LOS] = los_s;
            end
        end
        return v;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        // The read view lives here so that live monitor words retrigger it.
        rd_val = byte_at(r_ff.sel, r_ff.ptr);
        ctrl_view = byte_at(1'b1, OFS_CTRL);
        mon_view = byte_at(1'b1, OFS_RXPWR + 8'h01);
        nxt_r = r_ff;
        nxt_r.scl_q = scl_s;
        nxt_r.sda_q = sda_s;
        nxt_r.off_q = off_s;
        nxt_r.sda_out = 1'b0;
        if (bus_start) begin
            nxt_r.st = BUS_ADDR;
            nxt_r.cnt = 4'h0;
            nxt_r.sda_oe = 1'b0;
        end else if (bus_stop) begin
            nxt_r.st = BUS_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else if (scl_rise) begin
            nxt_r.sr = {r_ff.sr[6:0], sda_s};
            nxt_r.cnt = r_ff.cnt + 4'h1;
            if (r_ff.st == BUS_RDATA) nxt_r.sr = r_ff.sr;
            if (r_ff.st == BUS_RACK) nxt_r.ack = ~sda_s;
        end else if (scl_fall) begin
            case (r_ff.st)
                BUS_ADDR: begin
                    if (r_ff.cnt == BITS_PER_BYTE) begin
                        if (r_ff.sr[7:1] == DEV_ID || r_ff.sr[7:1] == DEV_DIAG) begin
                            nxt_r.sel = (r_ff.sr[7:1] == DEV_DIAG);
                            nxt_r.rw = r_ff.sr[0];
                            nxt_r.sda_oe = 1'b1;
                            nxt_r.st = BUS_AACK;
                        end else begin
                            nxt_r.st = BUS_IDLE;
                        end
                    end
                end
                BUS_AACK, BUS_RACK: begin
                    nxt_r.sda_oe = 1'b0;
                    nxt_r.cnt = 4'h0;
                    if (r_ff.st == BUS_AACK && !r_ff.rw) begin
                        nxt_r.st = BUS_PTR;
                    end else if (r_ff.st == BUS_RACK && !r_ff.ack) begin
                        nxt_r.st = BUS_IDLE;
                    end else begin
                        // The pointer wraps, so a long read sweeps all 256 bytes.
                        nxt_r.sr = rd_val;
                        nxt_r.sda_oe = ~rd_val[7];
                        nxt_r.ptr = r_ff.ptr + 8'h01;
                        nxt_r.st = BUS_RDATA;
                    end
                end
                BUS_PTR: begin
                    if (r_ff.cnt == BITS_PER_BYTE) begin
                        nxt_r.ptr = r_ff.sr;
                        nxt_r.sda_oe = 1'b1;
                        nxt_r.st = BUS_PACK;
                    end
                end
                BUS_PACK: begin
                    nxt_r.sda_oe = 1'b0;
                    nxt_r.cnt = 4'h0;
                    nxt_r.st = BUS_WDATA;
                end
                BUS_WDATA: begin
                    if (r_ff.cnt == BITS_PER_BYTE) begin
                        if (!r_ff.sel) begin
                            nxt_r.id_mem[r_ff.ptr] = r_ff.sr;
                        end else if (r_ff.ptr == OFS_CTRL) begin
                            nxt_r.soft_off = r_ff.sr[BIT_SOFT_OFF];
                        end else begin
                            nxt_r.dg_mem[r_ff.ptr] = r_ff.sr;
                        end
                        nxt_r.ptr = r_ff.ptr + 8'h01;
                        nxt_r.sda_oe = 1'b1;
                        nxt_r.st = BUS_PACK;
                    end
                end
                BUS_RDATA: begin
                    if (r_ff.cnt == BITS_PER_BYTE) begin
                        nxt_r.sda_oe = 1'b0;
                        nxt_r.st = BUS_RACK;
                    end else begin
                        nxt_r.sr = {r_ff.sr[6:0], 1'b0};
                        nxt_r.sda_oe = ~r_ff.sr[6];
                    end
                end
                default: nxt_r.st = BUS_IDLE;
            endcase
        end
        // A fault arriving on the clearing edge still latches.
        if (off_fall) nxt_r.fault = 1'b0;
        if (flt_s) nxt_r.fault = 1'b1;
        nxt_r.tx_fault = nxt_r.fault;
        nxt_r.tx_shutdown = off_s | nxt_r.soft_off | nxt_r.fault;
        nxt_r.los_out = los_s;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r_ff <= '0;
            r_ff.st <= BUS_IDLE;
            r_ff.scl_q <= LINE_RST;
            r_ff.sda_q <= LINE_RST;
            r_ff.off_q <= TX_OFF_RST;
            r_ff.soft_off <= SOFT_OFF_RST;
            r_ff.tx_shutdown <= TX_OFF_RST;
            r_ff.los_out <= LOS_RST;
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    assign sda_out = r_ff.sda_out;
    assign sda_oe = r_ff.sda_oe;
    assign tx_shutdown = r_ff.tx_shutdown;
    assign tx_fault = r_ff.tx_fault;
    assign receive_signal_lost = r_ff.los_out;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_shutdown_or: assert property (ce |=> tx_shutdown ==
        ($past(off_s) | r_ff.soft_off | r_ff.fault)) else $error("shutdown not OR of sources");
    chk_pin_off: assert property (ce && off_s |=> tx_shutdown)
        else $error("pin high but transmitter on");
    chk_fault_set: assert property (ce && flt_s |=> tx_fault && tx_shutdown)
        else $error("fault not latched");
    chk_fault_hold: assert property (ce && r_ff.fault && !off_fall |=> tx_fault)
        else $error("fault cleared without toggle");
    chk_fault_clear: assert property (ce && off_fall && !flt_s |=> !tx_fault)
        else $error("toggle did not clear fault");
    chk_ctrl_byte: assert property (ctrl_view ==
        {off_s, r_ff.soft_off, 3'b000, r_ff.fault, los_s, 1'b0}) else $error("byte 110 wrong");
    chk_los_mirror: assert property (ce |=> receive_signal_lost == $past(los_s))
        else $error("signal lost not mirrored");
    chk_monitor_live: assert property (mon_view == mon_rxpwr[7:0])
        else $error("monitor not live");
    chk_addr_ack: assert property (ce && scl_fall && !bus_start && !bus_stop &&
        r_ff.st == BUS_ADDR && r_ff.cnt == BITS_PER_BYTE && r_ff.sr[7:1] == DEV_DIAG
        |=> sda_oe && r_ff.sel) else $error("diag select not acknowledged");

    cov_read: cover property (r_ff.st == BUS_RDATA && r_ff.sel);
    cov_write_ctrl: cover property (r_ff.st == BUS_WDATA && r_ff.ptr == OFS_CTRL);
    cov_fault_clear: cover property (r_ff.fault ##1 !r_ff.fault);
endmodule // ptc_mgmt

// ### dv/ptc_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host board controller: two-wire master and transmit-off pin
// ==========================================================
module ptc_host (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_pull,
    output logic tx_off_pin
);
    logic off_en = 1'b0;
    logic off_val = 1'b0;
    // A host that lets go of the pin leaves it to the module pull-up.
    assign tx_off_pin = off_en ? off_val : 1'b1;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Pins move by non-blocking assignment on the rising clock, so no flop races them.
    task automatic drive_off(input logic en, input logic val);
        @(posedge clock);
        off_en <= en;
        off_val <= val;
    endtask
    // Stop when high, start or repeated start when low; the clock idles high.
    task automatic cond(input logic stop);
        repeat (4) @(posedge clock);
        sda_pull <= stop;
        repeat (4) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_pull <= ~stop;
        repeat (4) @(posedge clock);
        scl <= stop;
    endtask
    // One bit slot of 200 ns: data moves in the middle of the low half.
    task automatic bit_x(input logic b, output logic r);
        repeat (2) @(posedge clock);
        sda_pull <= ~b;
        repeat (2) @(posedge clock);
        scl <= 1'b1;
        repeat (2) @(posedge clock);
        r = sda;
        repeat (2) @(posedge clock);
        scl <= 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
        output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ack_in, ack_out);
    endtask
endmodule // ptc_host

// ### dv/tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the transceiver management block
// ==========================================================
module tb;
    import ptc_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic laser_fault_in = 1'b0;
    logic rx_lost_in = 1'b1;
    logic [15:0] mon [5] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0fed};
    logic scl, sda, sda_pull, tx_off_pin, sda_out, sda_oe, tx_shutdown, tx_fault;
    logic receive_signal_lost;
    logic ack;
    logic [7:0] rbuf [16];
    int num_errors = 0;
    int cmp_count = 0;
    always #12.5 clock = ~clock;
    // Open-drain data line: any party pulling wins, otherwise the pull-up.
    assign sda = ~sda_pull & (sda_oe ? sda_out : 1'b1);
    ptc_mgmt u_ptc_mgmt (.clock(clock), .arst_n(arst_n), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .tx_off_in(tx_off_pin),
        .laser_fault_in(laser_fault_in), .rx_lost_in(rx_lost_in), .mon_temp(mon[0]),
        .mon_vcc(mon[1]), .mon_bias(mon[2]), .mon_txpwr(mon[3]), .mon_rxpwr(mon[4]),
        .tx_shutdown(tx_shutdown), .tx_fault(tx_fault),
        .receive_signal_lost(receive_signal_lost));
    ptc_host u_ptc_host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(sda_pull),
        .tx_off_pin(tx_off_pin));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Control byte from {pin off, soft off, fault, signal lost}.
    function automatic logic [7:0] ctl(input logic [3:0] f);
        return {f[3], f[2], 3'h0, f[1], f[0], 1'b0};
    endfunction
    task automatic send(input logic [7:0] d, input logic exp_nak);
        logic [7:0] q;
        u_ptc_host.byte_x(d, 1'b1, q, ack);
        chk("ack", {7'h0, exp_nak}, {7'h0, ack});
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
        u_ptc_host.cond(1'b0);
        send({dev, 1'b0}, 1'b0);
        send(ofs, 1'b0);
        send(d, 1'b0);
        u_ptc_host.cond(1'b1);
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input int n);
        logic a;
        u_ptc_host.cond(1'b0);
        send({dev, 1'b0}, 1'b0);
        send(ofs, 1'b0);
        u_ptc_host.cond(1'b0);
        send({dev, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) u_ptc_host.byte_x(8'hff, i == n - 1, rbuf[i], a);
        u_ptc_host.cond(1'b1);
    endtask
    // Pin inputs pass two synchroniser flops and one register.
    task automatic settle();
        repeat (5) @(posedge clock);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        settle();
        chk("shutdown", 8'h01, {7'h0, tx_shutdown});
        rd(DEV_DIAG, OFS_CTRL, 1);
        chk("ctl", ctl(4'h9), rbuf[0]);
        u_ptc_host.drive_off(1'b1, 1'b0);
        settle();
        chk("shutdown", 8'h00, {7'h0, tx_shutdown});
        wr(DEV_DIAG, OFS_CTRL, 8'hbf);
        @(posedge clock);
        rx_lost_in <= 1'b0;
        settle();
        chk("lost", 8'h00, {7'h0, receive_signal_lost});
        rd(DEV_DIAG, OFS_CTRL, 1);
        chk("ctl", ctl(4'h0), rbuf[0]);
        wr(DEV_DIAG, OFS_CTRL, 8'h40);
        settle();
        chk("shutdown", 8'h01, {7'h0, tx_shutdown});
        rx_lost_in <= 1'b1;
        settle();
        rd(DEV_DIAG, OFS_CTRL, 1);
        chk("ctl", ctl(4'h5), rbuf[0]);
        wr(DEV_DIAG, OFS_CTRL, 8'h00);
        settle();
        chk("shutdown", 8'h00, {7'h0, tx_shutdown});
        // Fresh words on every monitor show that the burst reads live values.
        foreach (mon[k]) mon[k] <= ~mon[k];
        // Monitors read as one burst, most significant byte first.
        rd(DEV_DIAG, OFS_TEMP, 10);
        for (int i = 0; i < 10; i++) begin
            chk("mon", i[0] ? mon[i / 2][7:0] : mon[i / 2][15:8], rbuf[i]);
        end
        @(posedge clock);
        mon[1] <= 16'hbeef;
        settle();
        rd(DEV_DIAG, OFS_VCC, 2);
        chk("vcc hi", 8'hbe, rbuf[0]);
        chk("vcc lo", 8'hef, rbuf[1]);
        wr(DEV_ID, 8'hff, 8'h5a);
        wr(DEV_DIAG, 8'hff, 8'h33);
        rd(DEV_ID, 8'hff, 2);
        chk("id top", 8'h5a, rbuf[0]);
        chk("id wrap", 8'h00, rbuf[1]);
        rd(DEV_DIAG, 8'hff, 1);
        chk("diag top", 8'h33, rbuf[0]);
        u_ptc_host.cond(1'b0);
        send({7'h52, 1'b0}, 1'b1);
        u_ptc_host.cond(1'b1);
        @(posedge clock);
        laser_fault_in <= 1'b1;
        settle();
        chk("fault", 8'h01, {7'h0, tx_fault});
        chk("shutdown", 8'h01, {7'h0, tx_shutdown});
        laser_fault_in <= 1'b0;
        // Soft off cycling is not a clearing event; only the pin is.
        wr(DEV_DIAG, OFS_CTRL, 8'h40);
        wr(DEV_DIAG, OFS_CTRL, 8'h00);
        settle();
        chk("fault", 8'h01, {7'h0, tx_fault});
        rd(DEV_DIAG, OFS_CTRL, 1);
        chk("ctl", ctl(4'h3), rbuf[0]);
        u_ptc_host.drive_off(1'b1, 1'b1);
        settle();
        u_ptc_host.drive_off(1'b1, 1'b0);
        settle();
        chk("fault", 8'h00, {7'h0, tx_fault});
        chk("shutdown", 8'h00, {7'h0, tx_shutdown});
        // With the enable low even the synchronisers hold, so the old status stays.
        ce <= 1'b0;
        rx_lost_in <= 1'b0;
        settle();
        chk("lost frozen", 8'h01, {7'h0, receive_signal_lost});
        ce <= 1'b1;
        settle();
        chk("lost", 8'h00, {7'h0, receive_signal_lost});
        report_and_stop();
    end
endmodule // tb
